/* bench/serial_flash_status_register_test.sv */
`timescale 1ns/1ps
`include "status_reg_defs.svh"

module serial_flash_status_register_test;
	logic        ref_clk, nrst, busy, program_error, program_suspended, erase_suspended;
	logic        write_enable_latch, lockdown_freeze, wp_n;
	logic [1:0]  protection_summary;
	wire         cs_n, sck, si, so_line;
	logic        so, so_oe, protection_lock_flag, reset_command_enable, lockdown_command_enable;
	logic        sector_protect_allowed, wel_clear;
	logic        exp_lock, exp_reset_command_enable, exp_sle;
	logic [31:0] rx;
	int          errors, checked, pulses, p0;

	// released line shows the inverse of so, which is cleared to 0 on release, so it reads high
	assign so_line = so_oe ? so : ~so;

	initial ref_clk = 1'b0;
	always #4 ref_clk = ~ref_clk;

	serial_flash_status_register dut (
		.ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
		.so(so), .so_oe(so_oe), .busy(busy), .program_error(program_error),
		.program_suspended(program_suspended), .erase_suspended(erase_suspended),
		.protection_summary(protection_summary), .write_enable_latch(write_enable_latch),
		.lockdown_freeze(lockdown_freeze), .protection_lock_flag(protection_lock_flag),
		.reset_command_enable(reset_command_enable), .lockdown_command_enable(lockdown_command_enable),
		.sector_protect_allowed(sector_protect_allowed), .wel_clear(wel_clear)
	);

	spi_host_model host (.clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line));

	always @(posedge ref_clk) begin
		if (wel_clear === 1'b1) begin
			pulses <= pulses + 1;
		end
	end

	// ==========================================================
	// expected bytes from the levels the bench drives
	function automatic logic [7:0] b1(input logic bz);
		return {exp_lock, 1'b0, program_error, wp_n, protection_summary, write_enable_latch, bz};
	endfunction

	function automatic logic [7:0] b2(input logic bz);
		return {3'h0, exp_reset_command_enable, exp_sle, program_suspended, erase_suspended, bz};
	endfunction

	// ==========================================================
	// checks and tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic rd_chk();
		host.frame(`OP_READ_STATUS, 32'hA5C3_5A3C, 32, rx);
		check(rx, {b1(busy), b2(busy), b1(busy), b2(busy)}, "status");
		check({30'h0, so_oe, so}, 32'h0, "release");
	endtask

	task automatic wr(input logic [7:0] op, input logic [7:0] d, input int n = 8);
		int p;
		p = pulses;
		host.frame(op, {d, 24'h0}, n, rx);
		check(32'(pulses - p), 32'h1, "wel clear");
		check({28'h0, protection_lock_flag, reset_command_enable, lockdown_command_enable, sector_protect_allowed},
			{28'h0, exp_lock, exp_reset_command_enable, exp_sle, ~exp_lock}, "state");
	endtask

	task automatic tally_and_finish();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#500000;
		errors++;
		tally_and_finish();
	end

	// ==========================================================
	// main sequence
	initial begin
		nrst = 1'b0;
		{busy, program_error, program_suspended, erase_suspended, write_enable_latch, lockdown_freeze} = 6'h00;
		wp_n = 1'b1;
		protection_summary = 2'h3;
		{exp_lock, exp_reset_command_enable, exp_sle} = 3'h0;
		errors = 0;
		checked = 0;
		pulses = 0;
		repeat (12) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (4) @(negedge ref_clk);
		check({26'h0, so_oe, protection_lock_flag, reset_command_enable, lockdown_command_enable,
			sector_protect_allowed, wel_clear}, 32'h2, "reset");
		for (int k = 0; k < 4; k++) begin
			@(negedge ref_clk);
			{busy, program_error, program_suspended, erase_suspended} = {k[0], ~k[0], k[1], ~k[1]};
			{write_enable_latch, wp_n} = {k[0] ^ k[1], k[1]};
			protection_summary = 2'(k);
			rd_chk();
		end
		@(negedge ref_clk);
		busy = 1'b1;
		fork
			host.frame(`OP_READ_STATUS, 32'h0, 32, rx);
			begin
				#1562;
				@(negedge ref_clk);
				busy = 1'b0;
			end
		join
		check(rx, {b1(1'b1), b2(1'b0), b1(1'b0), b2(1'b0)}, "live busy");
		host.frame(`OP_READ_STATUS, 32'h0, 5, rx);
		check({30'h0, so_oe, so}, 32'h0, "mid abort");
		@(negedge ref_clk);
		{write_enable_latch, wp_n} = 2'b11;
		exp_lock = 1'b1;
		wr(`OP_WRITE_BYTE_ONE, 8'hFF);
		rd_chk();
		@(negedge ref_clk);
		wp_n = 1'b0;
		wr(`OP_WRITE_BYTE_ONE, 8'h00);
		@(negedge ref_clk);
		wp_n = 1'b1;
		exp_lock = 1'b0;
		wr(`OP_WRITE_BYTE_ONE, 8'h7F);
		@(negedge ref_clk);
		wp_n = 1'b0;
		exp_lock = 1'b1;
		wr(`OP_WRITE_BYTE_ONE, 8'h80);
		@(negedge ref_clk);
		wp_n = 1'b1;
		exp_lock = 1'b0;
		wr(`OP_WRITE_BYTE_ONE, 8'h00);
		{exp_reset_command_enable, exp_sle} = 2'b11;
		wr(`OP_WRITE_BYTE_TWO, 8'hFF);
		rd_chk();
		{exp_reset_command_enable, exp_sle} = 2'b00;
		wr(`OP_WRITE_BYTE_TWO, 8'hE7);
		exp_sle = 1'b1;
		wr(`OP_WRITE_BYTE_TWO, 8'h08);
		@(negedge ref_clk);
		lockdown_freeze = 1'b1;
		@(negedge ref_clk);
		lockdown_freeze = 1'b0;
		exp_sle = 1'b0;
		@(negedge ref_clk);
		check({31'h0, lockdown_command_enable}, 32'h0, "freeze");
		exp_reset_command_enable = 1'b1;
		wr(`OP_WRITE_BYTE_TWO, 8'h18);
		@(negedge ref_clk);
		write_enable_latch = 1'b0;
		wr(`OP_WRITE_BYTE_ONE, 8'h80);
		wr(`OP_WRITE_BYTE_TWO, 8'h00);
		@(negedge ref_clk);
		write_enable_latch = 1'b1;
		wr(`OP_WRITE_BYTE_TWO, 8'h00, 12);
		p0 = pulses;
		host.frame(8'hC7, 32'hFF00_0000, 8, rx);
		check(rx, 32'h0000_00FF, "ignored op");
		check(32'(pulses - p0), 32'h0, "ignored op wel");
		tally_and_finish();
	end
endmodule

/* bench/spi_host_model.sv */
`timescale 1ns/1ps

// ==========================================================
// host side of the serial link: frames one command, clocks data both ways
module spi_host_model (
	input  wire logic clk,
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so
);
	localparam realtime HALF = 62.5;

	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	// ==========================================================
	// opcode then nbits more clocks; so taken just before each rise
	task automatic frame(input logic [7:0] op, input logic [31:0] tx, input int nbits, output logic [31:0] rx);
		logic [39:0] bits;
		bits = {op, tx};
		rx = '0;
		// start just after a falling edge so no pin edge meets a sampling edge
		@(negedge clk);
		#0.25;
		cs_n = 1'b0;
		for (int i = 0; i < 8 + nbits; i++) begin
			si = bits[39 - i];
			#HALF;
			if (i >= 8) begin
				rx = {rx[30:0], so};
			end
			sck = 1'b1;
			#HALF;
			sck = 1'b0;
		end
		#HALF;
		cs_n = 1'b1;
		si = ~si;
		#200;
	endtask
endmodule

/* rtl/serial_flash_status_register.sv */
// Behaviour
// - status read is accepted at any time, even while busy
// - after the opcode a status bit goes out every clock, msb first
// - after byte two the output wraps to byte one while framed
// - each byte repetition is freshly sampled from live state
// - ready/busy sits in bit 0 of both bytes, sampled per byte
// - at high clock rates host reads four bytes; output keeps wrapping
// - chip select deassertion ends the read and floats the output
// - byte one bit 7 is the protection lock flag, default unlocked
// - byte one bit 5 is the read-only erase/program error flag
// - byte one bit 4 reads 0 while protect pin asserted, else 1
// - byte one bits 3:2 give software protection summary
// - byte one bit 1 shows the write enable latch
// - ready/busy reads 1 while an internal operation runs
// - byte two bit 4 enables the software reset command, default 0
// - byte two bit 3 enables lockdown commands, default 0
// - byte two bit 2 flags program suspend, read-only
// - byte two bit 1 flags erase suspend, read-only
// - write byte one changes only the lock flag
// - write byte two changes only bits 4 and 3
// - lock flag set blocks sector protect changes
// - lock flag clears at power-up, untouched by software reset
// - with protect pin asserted the lock flag may only be set
`timescale 1ns/1ps
`include "status_reg_defs.svh"

module serial_flash_status_register
	import status_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       cs_n,
	input  wire logic       sck,
	input  wire logic       si,
	input  wire logic       wp_n,
	output logic            so,
	output logic            so_oe,
	input  wire logic       busy,
	input  wire logic       program_error,
	input  wire logic       program_suspended,
	input  wire logic       erase_suspended,
	input  wire logic [1:0] protection_summary,
	input  wire logic       write_enable_latch,
	input  wire logic       lockdown_freeze,
	output logic            protection_lock_flag,
	output logic            reset_command_enable,
	output logic            lockdown_command_enable,
	output logic            sector_protect_allowed,
	output logic            wel_clear
);

	// ==========================================================
	// pin synchronisation and edge detection
	logic [3:0] pins_s;
	logic       cs_n_s;
	logic       sck_s;
	logic       si_s;
	logic       wp_n_s;
	logic       sck_d;
	logic       cs_n_d;
	logic       sck_rise;
	logic       sck_fall;
	logic       frame_end;

	sync2 #(
		.WIDTH (4),
		.INIT  (`SYNC_INIT)
	) u_pins (
		.clk  (ref_clk),
		.nrst (nrst),
		.d    ({cs_n, sck, si, wp_n}),
		.q    (pins_s)
	);

	assign cs_n_s    = pins_s[3];
	assign sck_s     = pins_s[2];
	assign si_s      = pins_s[1];
	assign wp_n_s    = pins_s[0];
	assign sck_rise  = sck_s & ~sck_d;
	assign sck_fall  = ~sck_s & sck_d;
	assign frame_end = cs_n_s & ~cs_n_d;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sck_d  <= 1'b0;
			cs_n_d <= 1'b1;
		end else begin
			sck_d  <= sck_s;
			cs_n_d <= cs_n_s;
		end
	end

	// ==========================================================
	// byte receiver
	logic [7:0] rx_byte;
	logic       byte_done;
	logic [2:0] bit_index;

	spi_shift_in u_rx (
		.clk          (ref_clk),
		.nrst         (nrst),
		.frame_active (~cs_n_s),
		.sck_rise     (sck_rise),
		.si_bit       (si_s),
		.rx_byte      (rx_byte),
		.byte_done    (byte_done),
		.bit_index    (bit_index)
	);

	// ==========================================================
	// frame state machine
	frame_state_e state;
	frame_state_e next_state;
	logic [7:0]   data_byte;
	logic [7:0]   next_data_byte;
	logic         got_byte;
	logic         next_got_byte;

	always_comb begin
		next_state     = state;
		next_data_byte = data_byte;
		next_got_byte  = got_byte;
		if (cs_n_s) begin
			next_state    = ST_IDLE;
			next_got_byte = 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					next_state = ST_OPCODE;
				end
				ST_OPCODE: begin
					if (byte_done) begin
						if (rx_byte == `OP_READ_STATUS) begin
							next_state = ST_READ;
						end else if (rx_byte == `OP_WRITE_BYTE_ONE) begin
							next_state = ST_WRITE_ONE;
						end else if (rx_byte == `OP_WRITE_BYTE_TWO) begin
							next_state = ST_WRITE_TWO;
						end else begin
							next_state = ST_IGNORE;
						end
					end
				end
				ST_WRITE_ONE, ST_WRITE_TWO: begin
					// only the first data byte counts, extras are ignored
					if (byte_done && !got_byte) begin
						next_data_byte = rx_byte;
						next_got_byte  = 1'b1;
					end
				end
				default: begin
					next_state = state;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state     <= ST_IDLE;
			data_byte <= 8'h00;
			got_byte  <= 1'b0;
		end else begin
			state     <= next_state;
			data_byte <= next_data_byte;
			got_byte  <= next_got_byte;
		end
	end

	// ==========================================================
	// writable bits
	logic write_ok;
	logic lock_clear_blocked;
	logic freeze_done;
	logic next_lock;
	logic next_reset_command_enable;
	logic next_sle;
	logic next_freeze_done;
	logic next_wel_clear;

	assign write_ok           = got_byte && (bit_index == `FIRST_BIT_INDEX) && write_enable_latch;
	assign lock_clear_blocked = ~wp_n_s && protection_lock_flag && ~data_byte[`B1_LOCK];

	always_comb begin
		next_lock        = protection_lock_flag;
		next_reset_command_enable        = reset_command_enable;
		next_sle         = lockdown_command_enable;
		next_freeze_done = freeze_done | lockdown_freeze;
		next_wel_clear   = 1'b0;
		if (frame_end && state == ST_WRITE_ONE) begin
			next_wel_clear = 1'b1;
			if (write_ok && !lock_clear_blocked) begin
				next_lock = data_byte[`B1_LOCK];
			end
		end
		if (frame_end && state == ST_WRITE_TWO) begin
			next_wel_clear = 1'b1;
			if (write_ok) begin
				next_reset_command_enable = data_byte[`B2_RESET_COMMAND_ENABLE];
				next_sle  = data_byte[`B2_SLE];
			end
		end
		// a frozen lockdown keeps its enable cleared for good
		if (next_freeze_done) begin
			next_sle = 1'b0;
		end
	end

	// reset here is power-up only; a software reset never reaches these bits
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			protection_lock_flag    <= `LOCK_RESET;
			reset_command_enable    <= `RESET_COMMAND_ENABLE_RESET;
			lockdown_command_enable <= `SLE_RESET;
			sector_protect_allowed  <= ~`LOCK_RESET;
			freeze_done             <= 1'b0;
			wel_clear               <= 1'b0;
		end else begin
			protection_lock_flag    <= next_lock;
			reset_command_enable    <= next_reset_command_enable;
			lockdown_command_enable <= next_sle;
			sector_protect_allowed  <= ~next_lock;
			freeze_done             <= next_freeze_done;
			wel_clear               <= next_wel_clear;
		end
	end

	// ==========================================================
	// live status bytes
	logic [7:0] byte_one;
	logic [7:0] byte_two;
	logic [7:0] fresh_byte;

	always_comb begin
		byte_one                = 8'h00;
		byte_one[`B1_LOCK]      = protection_lock_flag;
		byte_one[`B1_RESERVED]  = `RESERVED_VALUE;
		byte_one[`B1_ERROR]     = program_error;
		byte_one[`B1_PIN]       = wp_n_s;
		byte_one[`B1_SWP_HI]    = protection_summary[1];
		byte_one[`B1_SWP_LO]    = protection_summary[0];
		byte_one[`B1_WEL]       = write_enable_latch;
		byte_one[`BX_BUSY]      = busy;
		byte_two                = 8'h00;
		byte_two[`B2_RESET_COMMAND_ENABLE]      = reset_command_enable;
		byte_two[`B2_SLE]       = lockdown_command_enable;
		byte_two[`B2_PS]        = program_suspended;
		byte_two[`B2_ES]        = erase_suspended;
		byte_two[`BX_BUSY]      = busy;
	end

	// ==========================================================
	// status transmitter
	logic [6:0] tx_sh;
	logic [2:0] tx_cnt;
	logic       byte_sel;
	logic       load_byte;
	logic       next_so;
	logic       next_so_oe;
	logic [6:0] next_tx_sh;
	logic [2:0] next_tx_cnt;
	logic       next_byte_sel;

	assign fresh_byte = byte_sel ? byte_two : byte_one;
	assign load_byte  = (state == ST_READ) && !cs_n_s && sck_fall && (tx_cnt == `FIRST_BIT_INDEX);

	always_comb begin
		next_so       = so;
		next_so_oe    = so_oe;
		next_tx_sh    = tx_sh;
		next_tx_cnt   = tx_cnt;
		next_byte_sel = byte_sel;
		if (state != ST_READ || cs_n_s) begin
			next_so       = 1'b0;
			next_so_oe    = 1'b0;
			next_tx_cnt   = `FIRST_BIT_INDEX;
			next_byte_sel = 1'b0;
		end else if (sck_fall) begin
			next_so_oe  = 1'b1;
			next_tx_cnt = tx_cnt + 3'h1;
			if (load_byte) begin
				next_so    = fresh_byte[`BYTE_MSB];
				next_tx_sh = fresh_byte[6:0];
			end else begin
				next_so    = tx_sh[6];
				next_tx_sh = {tx_sh[5:0], 1'b0};
			end
			if (tx_cnt == `LAST_BIT_INDEX) begin
				next_byte_sel = ~byte_sel;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			so       <= 1'b0;
			so_oe    <= 1'b0;
			tx_sh    <= 7'h00;
			tx_cnt   <= `FIRST_BIT_INDEX;
			byte_sel <= 1'b0;
		end else begin
			so       <= next_so;
			so_oe    <= next_so_oe;
			tx_sh    <= next_tx_sh;
			tx_cnt   <= next_tx_cnt;
			byte_sel <= next_byte_sel;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_read_opcode;
		(state == ST_OPCODE) && byte_done && (rx_byte == `OP_READ_STATUS) && !cs_n_s;
	endsequence

	sequence s_last_bit_out;
		(state == ST_READ) && !cs_n_s && sck_fall && (tx_cnt == `LAST_BIT_INDEX);
	endsequence

	a_read_any_time: assert property (s_read_opcode |=> state == ST_READ)
		else $error("read status opcode not accepted");

	a_cs_release_hiz: assert property ($rose(cs_n_s) |=> !so_oe ##1 !so_oe)
		else $error("output still driven after chip select release");

	a_msb_first: assert property (load_byte |=> so_oe && so == $past(fresh_byte[`BYTE_MSB]))
		else $error("first bit of byte is not fresh msb");

	a_busy_each_byte: assert property (load_byte |=> tx_sh[0] == $past(busy))
		else $error("busy not sampled into bit 0");

	a_wrap_bytes: assert property (s_last_bit_out |=> byte_sel != $past(byte_sel))
		else $error("status bytes did not alternate");

	a_pin_reported: assert property (load_byte && !byte_sel |=> tx_sh[`B1_PIN] == $past(wp_n_s))
		else $error("protect pin state wrong in byte one");

	a_reserved_zero: assert property (load_byte |=> ($past(byte_sel) ? (so == 1'b0 && tx_sh[6:5] == 2'h0)
		: tx_sh[`B1_RESERVED] == 1'b0))
		else $error("reserved bit not zero");

	a_lock_wp_guard: assert property ($fell(protection_lock_flag) |-> $past(wp_n_s))
		else $error("lock flag cleared while pin asserted");

	a_write_one_scope: assert property (state == ST_WRITE_ONE |=>
		$stable(reset_command_enable) && ($stable(lockdown_command_enable) || !lockdown_command_enable))
		else $error("write byte one touched byte two");

	a_write_two_scope: assert property (state == ST_WRITE_TWO |=> $stable(protection_lock_flag))
		else $error("write byte two touched lock flag");

	a_lock_gates: assert property ((sector_protect_allowed == !protection_lock_flag)
		&& (!$changed(sector_protect_allowed) || $past(frame_end && state == ST_WRITE_ONE)))
		else $error("protect permission disagrees with lock flag");

	a_wel_needed: assert property (frame_end && !write_enable_latch |=>
		$stable(protection_lock_flag) && $stable(reset_command_enable))
		else $error("status write without write enable");

endmodule

/* rtl/spi_shift_in.sv */
`timescale 1ns/1ps
`include "status_reg_defs.svh"

module spi_shift_in (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       frame_active,
	input  wire logic       sck_rise,
	input  wire logic       si_bit,
	output logic      [7:0] rx_byte,
	output logic            byte_done,
	output logic      [2:0] bit_index
);

	// ==========================================================
	// receive shifter, msb first
	logic [7:0] next_rx_byte;
	logic       next_byte_done;
	logic [2:0] next_bit_index;

	always_comb begin
		next_rx_byte   = rx_byte;
		next_byte_done = 1'b0;
		next_bit_index = bit_index;
		if (!frame_active) begin
			next_bit_index = `FIRST_BIT_INDEX;
		end else if (sck_rise) begin
			next_rx_byte   = {rx_byte[6:0], si_bit};
			next_bit_index = bit_index + 3'h1;
			next_byte_done = (bit_index == `LAST_BIT_INDEX);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_byte   <= 8'h00;
			byte_done <= 1'b0;
			bit_index <= `FIRST_BIT_INDEX;
		end else begin
			rx_byte   <= next_rx_byte;
			byte_done <= next_byte_done;
			bit_index <= next_bit_index;
		end
	end

	// ==========================================================
	// checks
	a_byte_framing: assert property (@(posedge clk) disable iff (!nrst)
		byte_done |-> $past(bit_index) == `LAST_BIT_INDEX && $past(sck_rise))
		else $error("byte done without eighth bit");

endmodule

/* rtl/status_pkg.sv */
package status_pkg;

	// ==========================================================
	// frame state
	typedef enum logic [5:0] {
		ST_IDLE      = 6'h01,
		ST_OPCODE    = 6'h02,
		ST_READ      = 6'h04,
		ST_WRITE_ONE = 6'h08,
		ST_WRITE_TWO = 6'h10,
		ST_IGNORE    = 6'h20
	} frame_state_e;

endpackage

/* rtl/status_reg_defs.svh */
`ifndef STATUS_REG_DEFS_SVH
`define STATUS_REG_DEFS_SVH

// ==========================================================
// opcodes
`define OP_READ_STATUS      8'h05
`define OP_WRITE_BYTE_ONE   8'h01
`define OP_WRITE_BYTE_TWO   8'h31

// ==========================================================
// byte one field positions
`define B1_LOCK             7
`define B1_RESERVED         6
`define B1_ERROR            5
`define B1_PIN              4
`define B1_SWP_HI           3
`define B1_SWP_LO           2
`define B1_WEL              1

// ==========================================================
// byte two field positions
`define B2_RESET_COMMAND_ENABLE             4
`define B2_SLE              3
`define B2_PS               2
`define B2_ES               1

// ==========================================================
// shared
`define BX_BUSY             0
`define BYTE_MSB            7
`define LAST_BIT_INDEX      3'h7
`define FIRST_BIT_INDEX     3'h0
`define RESERVED_VALUE      1'b0
`define LOCK_RESET          1'b0
`define RESET_COMMAND_ENABLE_RESET          1'b0
`define SLE_RESET           1'b0
`define SYNC_INIT           4'h9

`endif

/* rtl/sync2.sv */
`timescale 1ns/1ps

module sync2 #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	// ==========================================================
	// two-stage synchroniser
	logic [WIDTH-1:0] stage;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage <= INIT;
			q     <= INIT;
		end else begin
			stage <= d;
			q     <= stage;
		end
	end

endmodule
